/* rtl/rfsw_pkg.sv */
// constants and types of the rf switch bus slave
package rfsw_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_PATH   = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h1A;
    localparam logic [4:0] ADDR_GROUP  = 5'h1B;
    localparam logic [4:0] ADDR_UNIQUE_SLAVE_ID   = 5'h1F;

    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int STAT_SWRST    = 7;
    localparam int STAT_CMD_PAR  = 6;
    localparam int STAT_LEN      = 5;
    localparam int STAT_ADDR_PAR = 4;
    localparam int STAT_DATA_PAR = 3;
    localparam int STAT_RD_UNUSED = 2;
    localparam int STAT_WR_UNUSED = 1;
    localparam int STAT_BCAST_RD = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PATH_RST   = 8'h00;
    localparam logic [6:0] FLAGS_RST  = 7'h00;
    localparam logic [3:0] GROUP_RST  = 4'h0;
    localparam logic [3:0] UNIQUE_SLAVE_ID_RST   = 4'hA;
    // upper identifier bits: value is arbitrary
    localparam logic [1:0] UNIQUE_SLAVE_ID_UPPER = 2'h0;
    localparam logic [3:0] BCAST_ID   = 4'h0;

    // ------------------------------------------------------------
    // frame lengths and command codes
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_LAST  = 4'hC;
    localparam logic [3:0] DATA_LAST = 4'h8;
    localparam logic [3:0] RD_BITS   = 4'h9;
    localparam logic [1:0] CMD_WR    = 2'h2;
    localparam logic [1:0] CMD_RD    = 2'h3;
    localparam logic [1:0] CMD_EXT   = 2'h0;

    // ------------------------------------------------------------
    // path-select codes on bits 6:0
    // ------------------------------------------------------------
    localparam logic [6:0] CODE_SLEEP = 7'h00;
    localparam logic [6:0] CODE_ISO   = 7'h7F;
    localparam logic [6:0] CODE_T1    = 7'h07;
    localparam logic [6:0] CODE_T2    = 7'h09;
    localparam logic [6:0] CODE_T3    = 7'h0B;
    localparam logic [6:0] CODE_T4    = 7'h0A;
    localparam logic [6:0] CODE_T5    = 7'h08;
    localparam logic [6:0] CODE_T6    = 7'h01;
    localparam logic [6:0] CODE_T7    = 7'h02;
    localparam logic [6:0] CODE_T8    = 7'h03;

    typedef struct packed {
        logic       sleep;
        logic       isolate;
        logic [7:0] throw_port;
    } rfsw_path_type;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'b000_0001,
        ST_CMD   = 7'b000_0010,
        ST_ADDR  = 7'b000_0100,
        ST_WDATA = 7'b000_1000,
        ST_PARK  = 7'b001_0000,
        ST_RDATA = 7'b010_0000,
        ST_RTAIL = 7'b100_0000
    } rfsw_state_type;

endpackage

/* rtl/rfsw_slave.sv */
// two-wire control bus slave driving an eight-throw switch path
module rfsw_slave (
    // clock, reset, enable
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   clk_en,
    // bus pins
    input  wire logic                   bus_clk,
    input  wire logic                   bus_data_in,
    output logic                        bus_data_out,
    output logic                        bus_data_oe_n,
    // switch control
    output rfsw_pkg::rfsw_path_type     path_sel
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic addr_valid(input logic [4:0] a);
        if (a == rfsw_pkg::ADDR_PATH)
            addr_valid = 1'b1;
        else if (a == rfsw_pkg::ADDR_STATUS)
            addr_valid = 1'b1;
        else if (a == rfsw_pkg::ADDR_GROUP)
            addr_valid = 1'b1;
        else if (a == rfsw_pkg::ADDR_UNIQUE_SLAVE_ID)
            addr_valid = 1'b1;
        else
            addr_valid = 1'b0;
    endfunction

    function automatic logic odd_ok9(input logic [8:0] f);
        odd_ok9 = ^f;
    endfunction

    function automatic rfsw_pkg::rfsw_path_type
        path_decode(input logic [6:0] c);
        path_decode = '0;
        case (c)
            rfsw_pkg::CODE_SLEEP: path_decode.sleep = 1'b1;
            rfsw_pkg::CODE_ISO:   path_decode.isolate = 1'b1;
            rfsw_pkg::CODE_T1:    path_decode.throw_port[0] = 1'b1;
            rfsw_pkg::CODE_T2:    path_decode.throw_port[1] = 1'b1;
            rfsw_pkg::CODE_T3:    path_decode.throw_port[2] = 1'b1;
            rfsw_pkg::CODE_T4:    path_decode.throw_port[3] = 1'b1;
            rfsw_pkg::CODE_T5:    path_decode.throw_port[4] = 1'b1;
            rfsw_pkg::CODE_T6:    path_decode.throw_port[5] = 1'b1;
            rfsw_pkg::CODE_T7:    path_decode.throw_port[6] = 1'b1;
            rfsw_pkg::CODE_T8:    path_decode.throw_port[7] = 1'b1;
            default:              path_decode = '0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic [1:0] pins_s;
    logic       sclk_s;
    logic       sdat_s;

    rfsw_sync #(
        .WIDTH (2)
    ) u_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .async_in ({bus_clk, bus_data_in}),
        .sync_out (pins_s)
    );

    assign sclk_s = pins_s[1];
    assign sdat_s = pins_s[0];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rfsw_pkg::rfsw_state_type  state_ff,  nxt_state;
    rfsw_pkg::rfsw_path_type   path_ff,   nxt_path;
    logic                      sclk_q_ff, nxt_sclk_q;
    logic                      sdat_q_ff, nxt_sdat_q;
    logic [3:0]                cnt_ff,    nxt_cnt;
    logic [11:0]               sh_ff,     nxt_sh;
    logic [8:0]                out_ff,    nxt_out;
    logic [4:0]                addr_ff,   nxt_addr;
    logic [7:0]                reg0_ff,   nxt_reg0;
    logic [6:0]                flags_ff,  nxt_flags;
    logic [3:0]                group_slave_id_ff,   nxt_group_slave_id;
    logic [3:0]                unique_slave_id_ff,   nxt_unique_slave_id;
    logic                      sdo_ff,    nxt_sdo;
    logic                      oe_n_ff,   nxt_oe_n;

    logic        rise;
    logic        fall;
    logic        ssc;
    logic [12:0] frame13;
    logic [8:0]  frame9;
    logic [6:0]  set_f;
    logic [6:0]  clr_f;
    logic        hit_u;
    logic        hit_g;
    logic        hit_b;
    logic [7:0]  rd_val;

    assign rise    = sclk_s & ~sclk_q_ff;
    assign fall    = ~sclk_s & sclk_q_ff;
    // data falling while the clock stays low marks a start
    assign ssc     = ~sclk_s & ~sclk_q_ff & ~sdat_s & sdat_q_ff;
    assign frame13 = {sh_ff, sdat_s};
    assign frame9  = {sh_ff[7:0], sdat_s};
    assign hit_u   = frame13[12:9] == unique_slave_id_ff;
    assign hit_g   = frame13[12:9] == group_slave_id_ff;
    assign hit_b   = frame13[12:9] == rfsw_pkg::BCAST_ID;

    always_comb
    begin
        rd_val = 8'h00;
        if (frame13[5:1] == rfsw_pkg::ADDR_PATH)
            rd_val = reg0_ff;
        else if (frame13[5:1] == rfsw_pkg::ADDR_STATUS)
            rd_val = {1'b0, flags_ff};
        else if (frame13[5:1] == rfsw_pkg::ADDR_GROUP)
            rd_val = {4'h0, group_slave_id_ff};
        else if (frame13[5:1] == rfsw_pkg::ADDR_UNIQUE_SLAVE_ID)
            rd_val = {2'h0, rfsw_pkg::UNIQUE_SLAVE_ID_UPPER, unique_slave_id_ff};
    end

    // ------------------------------------------------------------
    // sequence decoder
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_state  = state_ff;
        nxt_sclk_q = sclk_s;
        nxt_sdat_q = sdat_s;
        nxt_cnt    = cnt_ff;
        nxt_sh     = sh_ff;
        nxt_out    = out_ff;
        nxt_addr   = addr_ff;
        nxt_reg0   = reg0_ff;
        nxt_group_slave_id   = group_slave_id_ff;
        nxt_unique_slave_id   = unique_slave_id_ff;
        nxt_sdo    = sdo_ff;
        nxt_oe_n   = oe_n_ff;
        set_f      = '0;
        clr_f      = '0;
        if (ssc)
        begin
            // a start inside a sequence cuts the old one short
            if (state_ff != rfsw_pkg::ST_IDLE)
                set_f[rfsw_pkg::STAT_LEN] = 1'b1;
            nxt_state = rfsw_pkg::ST_CMD;
            nxt_cnt   = 4'h0;
            nxt_oe_n  = 1'b1;
        end
        else
        begin
            case (state_ff)
                rfsw_pkg::ST_CMD:
                begin
                    if (fall)
                    begin
                        nxt_sh  = frame13[11:0];
                        nxt_cnt = cnt_ff + 4'h1;
                        if (cnt_ff == rfsw_pkg::CMD_LAST)
                        begin
                            nxt_state = rfsw_pkg::ST_IDLE;
                            nxt_cnt   = 4'h0;
                            if (!(^frame13))
                                set_f[rfsw_pkg::STAT_CMD_PAR] = 1'b1;
                            else if (!(hit_u || hit_g || hit_b))
                                nxt_state = rfsw_pkg::ST_IDLE;
                            else if (frame13[8])
                            begin
                                nxt_reg0  = {1'b0, frame13[7:1]};
                                nxt_state = rfsw_pkg::ST_PARK;
                            end
                            else if (frame13[7:6] == rfsw_pkg::CMD_WR)
                            begin
                                if (!addr_valid(frame13[5:1]))
                                    set_f[rfsw_pkg::STAT_WR_UNUSED] = 1'b1;
                                nxt_addr  = frame13[5:1];
                                nxt_state = rfsw_pkg::ST_WDATA;
                            end
                            else if (frame13[7:6] == rfsw_pkg::CMD_RD)
                            begin
                                if (!hit_u)
                                    set_f[rfsw_pkg::STAT_BCAST_RD] = 1'b1;
                                else if (!addr_valid(frame13[5:1]))
                                    set_f[rfsw_pkg::STAT_RD_UNUSED] = 1'b1;
                                else
                                begin
                                    nxt_out   = {rd_val, ~^rd_val};
                                    nxt_state = rfsw_pkg::ST_RDATA;
                                    if (frame13[5:1] == rfsw_pkg::ADDR_STATUS)
                                        clr_f = '1;
                                end
                            end
                            else if (frame13[7:6] == rfsw_pkg::CMD_EXT)
                                nxt_state = rfsw_pkg::ST_ADDR;
                        end
                    end
                end
                rfsw_pkg::ST_ADDR:
                begin
                    if (fall)
                    begin
                        nxt_sh  = frame13[11:0];
                        nxt_cnt = cnt_ff + 4'h1;
                        if (cnt_ff == rfsw_pkg::DATA_LAST)
                        begin
                            // extended sequences are only checked, not run
                            if (!odd_ok9(frame9))
                                set_f[rfsw_pkg::STAT_ADDR_PAR] = 1'b1;
                            nxt_state = rfsw_pkg::ST_IDLE;
                        end
                    end
                end
                rfsw_pkg::ST_WDATA:
                begin
                    if (fall)
                    begin
                        nxt_sh  = frame13[11:0];
                        nxt_cnt = cnt_ff + 4'h1;
                        if (cnt_ff == rfsw_pkg::DATA_LAST)
                        begin
                            nxt_state = rfsw_pkg::ST_PARK;
                            if (!odd_ok9(frame9))
                                set_f[rfsw_pkg::STAT_DATA_PAR] = 1'b1;
                            else if (addr_ff == rfsw_pkg::ADDR_PATH)
                                nxt_reg0 = frame9[8:1];
                            else if (addr_ff == rfsw_pkg::ADDR_STATUS)
                            begin
                                if (frame9[rfsw_pkg::STAT_SWRST + 1])
                                begin
                                    nxt_reg0 = rfsw_pkg::PATH_RST;
                                    clr_f    = '1;
                                end
                            end
                            else if (addr_ff == rfsw_pkg::ADDR_GROUP)
                                nxt_group_slave_id = frame9[4:1];
                            else if (addr_ff == rfsw_pkg::ADDR_UNIQUE_SLAVE_ID)
                                nxt_unique_slave_id = frame9[4:1];
                        end
                    end
                end
                rfsw_pkg::ST_PARK:
                begin
                    if (fall)
                        nxt_state = rfsw_pkg::ST_IDLE;
                end
                rfsw_pkg::ST_RDATA:
                begin
                    // the master's park clock passes with nothing driven
                    if (rise && cnt_ff != 4'h0)
                    begin
                        nxt_oe_n = 1'b0;
                        if (cnt_ff <= rfsw_pkg::RD_BITS)
                        begin
                            nxt_sdo = out_ff[8];
                            nxt_out = {out_ff[7:0], 1'b0};
                            nxt_cnt = cnt_ff + 4'h1;
                        end
                        else
                        begin
                            nxt_sdo   = 1'b0;
                            nxt_state = rfsw_pkg::ST_RTAIL;
                        end
                    end
                    else if (fall && cnt_ff == 4'h0)
                        nxt_cnt = 4'h1;
                end
                rfsw_pkg::ST_RTAIL:
                begin
                    if (fall)
                    begin
                        nxt_oe_n  = 1'b1;
                        nxt_state = rfsw_pkg::ST_IDLE;
                    end
                end
                default:
                    nxt_state = rfsw_pkg::ST_IDLE;
            endcase
        end
        // a new error wins over a clear in the same cycle
        nxt_flags = (flags_ff & ~clr_f) | set_f;
        nxt_path  = path_decode(reg0_ff[6:0]);
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff  <= rfsw_pkg::ST_IDLE;
            path_ff   <= '0;
            sclk_q_ff <= 1'b0;
            sdat_q_ff <= 1'b0;
            cnt_ff    <= 4'h0;
            sh_ff     <= 12'h000;
            out_ff    <= 9'h000;
            addr_ff   <= 5'h00;
            reg0_ff   <= rfsw_pkg::PATH_RST;
            flags_ff  <= rfsw_pkg::FLAGS_RST;
            group_slave_id_ff   <= rfsw_pkg::GROUP_RST;
            unique_slave_id_ff   <= rfsw_pkg::UNIQUE_SLAVE_ID_RST;
            sdo_ff    <= 1'b0;
            oe_n_ff   <= 1'b1;
        end
        else if (clk_en)
        begin
            state_ff  <= nxt_state;
            path_ff   <= nxt_path;
            sclk_q_ff <= nxt_sclk_q;
            sdat_q_ff <= nxt_sdat_q;
            cnt_ff    <= nxt_cnt;
            sh_ff     <= nxt_sh;
            out_ff    <= nxt_out;
            addr_ff   <= nxt_addr;
            reg0_ff   <= nxt_reg0;
            flags_ff  <= nxt_flags;
            group_slave_id_ff   <= nxt_group_slave_id;
            unique_slave_id_ff   <= nxt_unique_slave_id;
            sdo_ff    <= nxt_sdo;
            oe_n_ff   <= nxt_oe_n;
        end
    end

    assign bus_data_out  = sdo_ff;
    assign bus_data_oe_n = oe_n_ff;
    assign path_sel      = path_ff;

endmodule

/* rtl/rfsw_sync.sv */
// two-flop synchroniser for pins from outside the ref_clk domain
module rfsw_sync #(
    parameter int WIDTH = 2
) (
    // clock, reset and enable
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    always_comb
    begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else if (clk_en)
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;

endmodule

/* tb/rfsw_master_model.sv */
// behavioural bus master facing the slave
module rfsw_master_model (
    // clock
    input  wire logic ref_clk,
    // bus pins
    output logic      bus_clk,
    output logic      drv_data,
    output logic      drv_en,
    input  wire logic bus_line
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF = 400;

    initial
    begin
        bus_clk = 1'b0;
        drv_data = 1'b0;
        drv_en = 1'b1;
    end

    // idle gap, then data falls with the clock low
    task automatic ssc();
        @(negedge ref_clk);
        #(2 * HALF);
        drv_en = 1'b1;
        drv_data = 1'b1;
        #HALF;
        drv_data = 1'b0;
        #HALF;
    endtask

    // data changes on the rise, slave samples on the fall
    task automatic tick(input logic b);
        bus_clk = 1'b1;
        drv_data = b;
        #HALF;
        bus_clk = 1'b0;
        #HALF;
    endtask

    // bad flips the parity bit on purpose
    task automatic frame(input logic [11:0] v, input int n, input logic bad);
        logic p;
        p = 1'b1;
        for (int i = n - 1; i >= 0; i--)
        begin
            p = p ^ v[i];
            tick(v[i]);
        end
        tick(p ^ bad);
    endtask

    // park hands the line over, nine bits back, park, take it again
    task automatic get(output logic [8:0] v);
        drv_en = 1'b0;
        tick(1'b0);
        v = 9'h000;
        for (int i = 0; i < 9; i++)
        begin
            bus_clk = 1'b1;
            #HALF;
            v = {v[7:0], bus_line};
            bus_clk = 1'b0;
            #HALF;
        end
        tick(1'b0);
        drv_en = 1'b1;
    endtask
endmodule

/* tb/rfsw_slave_sva.sv */
// port checker for the rf switch bus slave
module rfsw_slave_sva (
    // clock, reset, enable
    input wire logic                    ref_clk,
    input wire logic                    sys_rst,
    input wire logic                    clk_en,
    // bus pins
    input wire logic                    bus_clk,
    input wire logic                    bus_data_in,
    input wire logic                    bus_data_out,
    input wire logic                    bus_data_oe_n,
    // switch control
    input wire rfsw_pkg::rfsw_path_type path_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------
    // drive length counter
    // ----------------------------------------
    logic [7:0] low_cnt_ff;
    logic [7:0] nxt_low_cnt;

    always_comb
    begin
        nxt_low_cnt = 8'h00;
        if (!bus_data_oe_n)
            nxt_low_cnt = (low_cnt_ff == 8'hFF) ? low_cnt_ff
                                                : low_cnt_ff + 8'h01;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            low_cnt_ff <= 8'h00;
        else
            low_cnt_ff <= nxt_low_cnt;
    end

    // ----------------------------------------
    // edge sequences
    // ----------------------------------------
    // sync delay leaves a cycle of slack either way
    sequence clk_high_before;
        $past(bus_clk, 2) && $past(bus_clk, 3);
    endsequence
    sequence clk_low_before;
        !$past(bus_clk, 2) && !$past(bus_clk, 3);
    endsequence

    a_path_onehot: assert property ($onehot0(path_sel))
        else $error("path select not one-hot");
    a_path_after_fall: assert property (
        $changed(path_sel) |-> clk_low_before)
        else $error("path changed away from a falling bus edge");
    a_drive_on_rise: assert property (
        $fell(bus_data_oe_n) |-> clk_high_before)
        else $error("drive began away from a rising bus edge");
    a_release_on_fall: assert property (
        $rose(bus_data_oe_n) |-> clk_low_before)
        else $error("release away from a falling bus edge");
    a_data_on_rise: assert property (
        !bus_data_oe_n && $past(!bus_data_oe_n)
        && $changed(bus_data_out) |-> clk_high_before)
        else $error("read bit changed away from a rising edge");
    a_drive_holds_bit: assert property (
        $fell(bus_data_oe_n) |-> !bus_data_oe_n [*8])
        else $error("read bit held under one bus period");
    a_drive_bounded: assert property (low_cnt_ff <= 8'h54)
        else $error("line held past the final park");
    a_read_no_path: assert property (
        !bus_data_oe_n |-> $stable(path_sel))
        else $error("path changed during a read");
endmodule

bind rfsw_slave rfsw_slave_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .bus_clk(bus_clk), .bus_data_in(bus_data_in),
    .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
    .path_sel(path_sel));

/* tb/rfsw_slave_tb_top.sv */
// self-checking bench for the rf switch bus slave
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
    mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end end

module rfsw_slave_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic                    ref_clk;
    logic                    sys_rst;
    logic                    clk_en;
    logic                    bus_clk;
    logic                    bus_line;
    logic                    bus_data_out;
    logic                    bus_data_oe_n;
    logic                    drv_data;
    logic                    drv_en;
    rfsw_pkg::rfsw_path_type path_sel;
    int                      mismatches;
    int                      n_checks;
    int                      cycles;
    logic [8:0]              rd_v;
    logic [6:0]              codes [8];

    // pull-down: a silent slave reads as all zeros, bad parity included
    assign bus_line = !bus_data_oe_n ? bus_data_out : (drv_en & drv_data);

    rfsw_slave uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .bus_clk(bus_clk), .bus_data_in(bus_line),
        .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
        .path_sel(path_sel));
    rfsw_master_model m (.ref_clk(ref_clk), .bus_clk(bus_clk),
        .drv_data(drv_data), .drv_en(drv_en), .bus_line(bus_line));

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // sequences
    // ----------------------------------------
    function automatic logic [8:0] wp(input logic [7:0] d);
        return {d, ~^d};
    endfunction

    task automatic wr(input logic [3:0] sa, input logic [4:0] a,
                      input logic [7:0] d, input logic bc, input logic bd);
        m.ssc();
        m.frame({sa, 3'b010, a}, 12, bc);
        m.frame({4'h0, d}, 8, bd);
        m.tick(1'b0);
    endtask

    task automatic r0(input logic [3:0] sa, input logic [6:0] d,
                      input logic bc);
        m.ssc();
        m.frame({sa, 1'b1, d}, 12, bc);
        m.tick(1'b0);
    endtask

    task automatic rd(input logic [3:0] sa, input logic [4:0] a,
                      input logic [8:0] exp);
        m.ssc();
        m.frame({sa, 3'b011, a}, 12, 1'b0);
        m.get(rd_v);
        `CHK(rd_v, exp)
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // about 6400 cycles are needed
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        mismatches = 0;
        n_checks = 0;
        cycles = 0;
        codes = '{7'h07, 7'h09, 7'h0B, 7'h0A, 7'h08, 7'h01, 7'h02, 7'h03};
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (10) @(negedge ref_clk);
        `CHK(path_sel, 10'h200)
        for (int i = 0; i < 8; i++)
        begin
            r0(4'hA, codes[i], 1'b0);
            `CHK(path_sel, 10'h001 << i)
        end
        r0(4'hA, 7'h00, 1'b0);
        `CHK(path_sel, 10'h200)
        r0(4'hA, 7'h7F, 1'b0);
        `CHK(path_sel, 10'h100)
        wr(4'hA, 5'h00, 8'h8B, 1'b0, 1'b0);
        `CHK(path_sel, 10'h004)
        r0(4'hA, 7'h08, 1'b0);
        rd(4'hA, 5'h00, wp(8'h08));
        r0(4'hA, 7'h01, 1'b1);
        `CHK(path_sel, 10'h010)
        rd(4'hA, 5'h1A, wp(8'h40));
        wr(4'hA, 5'h00, 8'h01, 1'b0, 1'b1);
        `CHK(path_sel, 10'h010)
        rd(4'hA, 5'h1A, wp(8'h08));
        wr(4'hA, 5'h05, 8'h55, 1'b0, 1'b0);
        rd(4'hA, 5'h1A, wp(8'h02));
        rd(4'hA, 5'h05, 9'h000);
        rd(4'hA, 5'h1A, wp(8'h04));
        // sequence cut short by a fresh start
        m.ssc();
        repeat (5) m.tick(1'b1);
        r0(4'hA, 7'h01, 1'b0);
        `CHK(path_sel, 10'h020)
        rd(4'hA, 5'h1A, wp(8'h20));
        // extended command with a bad address frame
        m.ssc();
        m.frame({4'hA, 3'b000, 5'h00}, 12, 1'b0);
        m.frame(12'h000, 8, 1'b1);
        m.tick(1'b0);
        rd(4'hA, 5'h1A, wp(8'h10));
        wr(4'hA, 5'h1F, 8'h05, 1'b0, 1'b0);
        rd(4'h5, 5'h1F, wp(8'h05));
        r0(4'hA, 7'h02, 1'b0);
        `CHK(path_sel, 10'h020)
        wr(4'h5, 5'h1B, 8'h03, 1'b0, 1'b0);
        r0(4'h3, 7'h03, 1'b0);
        `CHK(path_sel, 10'h080)
        rd(4'h3, 5'h00, 9'h000);
        rd(4'h0, 5'h00, 9'h000);
        rd(4'h5, 5'h1A, wp(8'h01));
        r0(4'h0, 7'h07, 1'b0);
        `CHK(path_sel, 10'h001)
        r0(4'h5, 7'h00, 1'b1);
        wr(4'h5, 5'h1A, 8'h80, 1'b0, 1'b0);
        `CHK(path_sel, 10'h200)
        rd(4'h5, 5'h1A, wp(8'h00));
        print_verdict();
    end
endmodule
